// *** include/dmt_pkg.sv ***
// Constants and state type for the dual mode timer/counter block
`default_nettype none
package dmt_pkg;
  // Core clock rate
  localparam int unsigned CORE_CLOCK_HZ = 125_000_000;

  // Special function register addresses
  localparam logic [7:0] ADDR_CONTROL  = 8'h88;
  localparam logic [7:0] ADDR_MODE     = 8'h89;
  localparam logic [7:0] ADDR_LOW_0    = 8'h8A;
  localparam logic [7:0] ADDR_LOW_1    = 8'h8B;
  localparam logic [7:0] ADDR_HIGH_0   = 8'h8C;
  localparam logic [7:0] ADDR_HIGH_1   = 8'h8D;
  localparam logic [7:0] ADDR_LOW_2    = 8'hCC;
  localparam logic [7:0] ADDR_HIGH_2   = 8'hCD;

  // Control register bit positions
  localparam int unsigned BIT_FLAG_1 = 7;
  localparam int unsigned BIT_RUN_1  = 6;
  localparam int unsigned BIT_FLAG_0 = 5;
  localparam int unsigned BIT_RUN_0  = 4;

  // Mode register field positions, timer 1 in the upper nibble
  localparam int unsigned BIT_GATE_1   = 7;
  localparam int unsigned BIT_SOURCE_1 = 6;
  localparam int unsigned MODE_1_LSB   = 4;
  localparam int unsigned BIT_GATE_0   = 3;
  localparam int unsigned BIT_SOURCE_0 = 2;
  localparam int unsigned MODE_0_LSB   = 0;

  // Counter modes
  typedef enum logic [1:0] {
    DMT_MODE_13     = 2'b00,
    DMT_MODE_16     = 2'b01,
    DMT_MODE_RELOAD = 2'b10,
    DMT_MODE_SPLIT  = 2'b11
  } dmt_mode_t;

  // Prescaler terminal counts, divide by 4 and by 12
  localparam logic [1:0] DIV4_LAST  = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hB;

  // Value of every control and count register after reset
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Whole state of the block
  typedef struct packed {
    logic [2:0]  ev_meta;
    logic [2:0]  ev_sync;
    logic [2:0]  ev_prev;
    logic [1:0]  gate_meta;
    logic [1:0]  gate_sync;
    logic        flag1;
    logic        run1;
    logic        flag0;
    logic        run0;
    logic [7:0]  mode;
    logic [7:0]  low0;
    logic [7:0]  high0;
    logic [7:0]  low1;
    logic [7:0]  high1;
    logic [15:0] count2;
    logic [1:0]  div4;
    logic [3:0]  div12;
    logic [2:0]  pulse;
    logic [7:0]  rdata;
  } dmt_state_t;
endpackage
`default_nettype wire

// *** hw/dmt_timer.sv ***
// Timer/counter block: timers 0 and 1 with four modes, plain timer 2
`default_nettype none
module dmt_timer
  import dmt_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] sfr_addr_in,
  input  wire logic [7:0] sfr_wdata_in,
  input  wire logic       sfr_write_in,
  input  wire logic       sfr_read_in,
  output logic      [7:0] sfr_rdata_out,
  input  wire logic       event_pin_0_in,
  input  wire logic       event_pin_1_in,
  input  wire logic       event_pin_2_in,
  input  wire logic       ext_irq_pin_0_in,
  input  wire logic       ext_irq_pin_1_in,
  input  wire logic       rate_select_0_in,
  input  wire logic       rate_select_1_in,
  input  wire logic       timer2_run_in,
  input  wire logic       timer2_source_in,
  input  wire logic       timer2_out_enable_in,
  input  wire logic       irq_ack_0_in,
  input  wire logic       irq_ack_1_in,
  output logic            overflow_pulse_0_out,
  output logic            overflow_pulse_1_out,
  output logic            overflow_pulse_2_out,
  output logic            overflow_pulse_2_oe_out
);
  import dmt_pkg::*;

  dmt_state_t st;
  dmt_state_t next_st;

  logic        tick4;
  logic        tick12;
  logic [2:0]  fall;
  logic        pre0;
  logic        pre1;
  logic        src0;
  logic        src1;
  logic        src2;
  logic        open0;
  logic        open1;
  logic        split0;
  logic        wr_cnt0;
  logic        wr_cnt1;
  logic        wr_cnt2;
  logic        inc0;
  logic        inc0h;
  logic        inc1;
  logic        inc2;
  logic [16:0] step0;
  logic [16:0] step1;
  logic        ovf0;
  logic        ovf0h;
  logic        ovf1;
  logic        ovf2;
  logic [7:0]  rd_mux;
  dmt_mode_t   mode0;
  dmt_mode_t   mode1;

  // One increment of a timer in modes 0 to 2; returns {overflow, high, low}.
  // Mode 3 returns the count unchanged, which is what stops timer 1.
  function automatic logic [16:0] dmt_step(input dmt_mode_t  m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0]  s8;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8  = {1'b0, lo} + 9'h001;
    case (m)
      // 13-bit counter layout; upper low bits simply keep their value
      DMT_MODE_13:     dmt_step = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
      DMT_MODE_16:     dmt_step = s16;
      // reload low byte from high byte
      DMT_MODE_RELOAD: dmt_step = {s8[8], hi, (s8[8] ? hi : s8[7:0])};
      default:         dmt_step = {1'b0, hi, lo};
    endcase
  endfunction

  assign mode0  = dmt_mode_t'(st.mode[MODE_0_LSB +: 2]);
  assign mode1  = dmt_mode_t'(st.mode[MODE_1_LSB +: 2]);
  assign split0 = (mode0 == DMT_MODE_SPLIT);

  // prescaler ticks from the free running dividers
  assign tick4  = (st.div4 == DIV4_LAST);
  assign tick12 = (st.div12 == DIV12_LAST);

  // falling edges seen only on the second synchroniser stage
  assign fall = st.ev_prev & ~st.ev_sync;

  // clock source choice; a low rate select keeps the /12 default
  assign pre0 = rate_select_0_in ? tick4 : tick12;
  assign pre1 = rate_select_1_in ? tick4 : tick12;
  assign src0 = st.mode[BIT_SOURCE_0] ? fall[0] : pre0;
  assign src1 = st.mode[BIT_SOURCE_1] ? fall[1] : pre1;
  assign src2 = timer2_source_in ? fall[2] : tick12;

  // gate opens only while the synchronised interrupt pin is high
  assign open0 = ~st.mode[BIT_GATE_0] | st.gate_sync[0];
  assign open1 = ~st.mode[BIT_GATE_1] | st.gate_sync[1];

  // A software write to a count byte takes priority over that cycle's step
  assign wr_cnt0 = sfr_write_in & (sfr_addr_in == ADDR_LOW_0 || sfr_addr_in == ADDR_HIGH_0);
  assign wr_cnt1 = sfr_write_in & (sfr_addr_in == ADDR_LOW_1 || sfr_addr_in == ADDR_HIGH_1);
  assign wr_cnt2 = sfr_write_in & (sfr_addr_in == ADDR_LOW_2 || sfr_addr_in == ADDR_HIGH_2);

  assign inc0  = st.run0 & open0 & src0 & ~wr_cnt0;
  // split high byte: prescaled clock only, timer 1 run bit
  assign inc0h = split0 & st.run1 & pre0 & ~wr_cnt0;
  // with timer 0 split, timer 1 is switched by its mode bits alone
  assign inc1  = (split0 | st.run1) & open1 & src1 & ~wr_cnt1;
  // timer 2 is an up counter only
  assign inc2  = timer2_run_in & src2 & ~wr_cnt2;

  assign step0 = dmt_step(mode0, st.low0, st.high0);
  assign step1 = dmt_step(mode1, st.low1, st.high1);

  // overflow of timer 0 depends on split mode
  assign ovf0  = inc0 & (split0 ? (st.low0 == 8'hFF) : step0[16]);
  assign ovf0h = inc0h & (st.high0 == 8'hFF);
  assign ovf1  = inc1 & step1[16];
  assign ovf2  = inc2 & (st.count2 == 16'hFFFF);

  // byte wide read access to the registers
  always_comb begin
    case (sfr_addr_in)
      ADDR_CONTROL: rd_mux = {st.flag1, st.run1, st.flag0, st.run0, 4'h0};
      ADDR_MODE:    rd_mux = st.mode;
      ADDR_LOW_0:   rd_mux = st.low0;
      ADDR_HIGH_0:  rd_mux = st.high0;
      ADDR_LOW_1:   rd_mux = st.low1;
      ADDR_HIGH_1:  rd_mux = st.high1;
      ADDR_LOW_2:   rd_mux = st.count2[7:0];
      ADDR_HIGH_2:  rd_mux = st.count2[15:8];
      default:      rd_mux = 8'h00;
    endcase
  end

  // Next state of the whole block
  always_comb begin
    next_st = st;
    // Synchronisers: first stage feeds only the second
    next_st.ev_meta   = {event_pin_2_in, event_pin_1_in, event_pin_0_in};
    next_st.ev_sync   = st.ev_meta;
    next_st.ev_prev   = st.ev_sync;
    next_st.gate_meta = {ext_irq_pin_1_in, ext_irq_pin_0_in};
    next_st.gate_sync = st.gate_meta;
    // dividers run straight from the core clock
    next_st.div4  = st.div4 + 2'h1;
    next_st.div12 = tick12 ? 4'h0 : st.div12 + 4'h1;

    // Count updates
    if (inc0) begin
      if (split0) begin
        next_st.low0 = st.low0 + 8'h01;
      end else begin
        next_st.high0 = step0[15:8];
        next_st.low0  = step0[7:0];
      end
    end
    if (inc0h) begin
      next_st.high0 = st.high0 + 8'h01;
    end
    if (inc1) begin
      next_st.high1 = step1[15:8];
      next_st.low1  = step1[7:0];
    end
    if (inc2) begin
      next_st.count2 = st.count2 + 16'h0001;
    end

    // Register writes
    if (sfr_write_in) begin
      case (sfr_addr_in)
        ADDR_CONTROL: begin
          next_st.flag1 = sfr_wdata_in[BIT_FLAG_1];
          next_st.run1  = sfr_wdata_in[BIT_RUN_1];
          next_st.flag0 = sfr_wdata_in[BIT_FLAG_0];
          next_st.run0  = sfr_wdata_in[BIT_RUN_0];
        end
        ADDR_MODE:   next_st.mode = sfr_wdata_in;
        ADDR_LOW_0:  next_st.low0 = sfr_wdata_in;
        ADDR_HIGH_0: next_st.high0 = sfr_wdata_in;
        ADDR_LOW_1:  next_st.low1 = sfr_wdata_in;
        ADDR_HIGH_1: next_st.high1 = sfr_wdata_in;
        ADDR_LOW_2:  next_st.count2[7:0] = sfr_wdata_in;
        ADDR_HIGH_2: next_st.count2[15:8] = sfr_wdata_in;
        default: begin
          next_st.mode = st.mode;
        end
      endcase
    end

    // vectoring clears the flag, a same-cycle overflow still sets it
    if (irq_ack_0_in) begin
      next_st.flag0 = 1'b0;
    end
    if (irq_ack_1_in) begin
      next_st.flag1 = 1'b0;
    end
    if (ovf0) begin
      next_st.flag0 = 1'b1;
    end
    // split high byte borrows the timer 1 flag
    if (split0 ? ovf0h : ovf1) begin
      next_st.flag1 = 1'b1;
    end

    // one-cycle overflow pulses; timer 1 and 2 pulses feed the baud logic
    next_st.pulse = {ovf2, ovf1, ovf0};

    // Read data is captured so the bus sees a registered value
    if (sfr_read_in) begin
      next_st.rdata = rd_mux;
    end
  end

  // State register; reset forces every field to zero
  always_ff @(posedge sys_clk_in) begin
    if (!resetn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sfr_rdata_out           = st.rdata;
  assign overflow_pulse_0_out    = st.pulse[0];
  assign overflow_pulse_1_out    = st.pulse[1];
  // timer 2 output pin is driven only while enabled
  assign overflow_pulse_2_out    = st.pulse[2] & timer2_out_enable_in;
  assign overflow_pulse_2_oe_out = timer2_out_enable_in;

  // Checks kept beside the logic they guard
  a_pulse_single: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    overflow_pulse_0_out |=> !overflow_pulse_0_out)
    else $error("overflow pulse 0 held longer than one clock");

  a_mode0_wrap: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode0 == DMT_MODE_13 && inc0 && st.high0 == 8'hFF && st.low0[4:0] == 5'h1F)
    |=> (st.high0 == 8'h00 && st.low0[4:0] == 5'h00 && st.flag0 && overflow_pulse_0_out))
    else $error("mode 0 wrap did not clear count and raise flag");

  a_mode1_wrap: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode1 == DMT_MODE_16 && inc1 && {st.high1, st.low1} == 16'hFFFF && !irq_ack_1_in)
    |=> ({st.high1, st.low1} == 16'h0000 && overflow_pulse_1_out && (split0 || st.flag1)))
    else $error("mode 1 wrap misbehaved");

  a_reload_value: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode0 == DMT_MODE_RELOAD && inc0 && st.low0 == 8'hFF)
    |=> (st.low0 == $past(st.high0) && st.flag0))
    else $error("mode 2 reload did not load high byte");

  a_run_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (!st.run0 && !wr_cnt0) |=> (st.low0 == $past(st.low0)))
    else $error("timer 0 low byte moved while stopped");

  a_gate_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st.mode[BIT_GATE_1] && !st.gate_sync[1] && !wr_cnt1)
    |=> $stable({st.high1, st.low1}))
    else $error("gated timer 1 advanced with pin low");

  a_stop_mode: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (mode1 == DMT_MODE_SPLIT && !wr_cnt1) |=> $stable({st.high1, st.low1}))
    else $error("timer 1 counted in mode 3");

  a_flag_wins: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (ovf0 && irq_ack_0_in) |=> st.flag0)
    else $error("overflow lost against vector clear");

  a_up_count: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    inc2 |=> (st.count2 == $past(st.count2) + 16'h0001))
    else $error("timer 2 did not count up by one");

  a_div_twelve: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (tick12 && $past(resetn_in, 12)) |-> ($past(tick12, 12) && !$past(tick12, 6)))
    else $error("divide by twelve spacing wrong");

  a_edge_step: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (st.mode[BIT_SOURCE_0] && !st.mode[BIT_GATE_0] && st.run0 && !split0
     && mode0 == DMT_MODE_16 && fall[0] && !wr_cnt0)
    |=> ({st.high0, st.low0} == $past({st.high0, st.low0}) + 16'h0001))
    else $error("event edge did not advance count by one");

  a_split_high: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (split0 && !st.run1 && !wr_cnt0) |=> $stable(st.high0))
    else $error("split high byte counted without timer 1 run");

  // Pulse 1 feeds the baud logic, so a stretched pulse would double a baud tick
  a_pulse_single_1: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    overflow_pulse_1_out
    |=> !overflow_pulse_1_out)
    else $error("overflow pulse 1 held longer than one clock");

  a_pulse_single_2: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    overflow_pulse_2_out
    |=> !overflow_pulse_2_out)
    else $error("overflow pulse 2 held longer than one clock");

  // Split high byte wraps to zero and reports through the timer 1 flag
  a_split_flag: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (split0 && ovf0h)
    |=> (st.flag1 && st.high0 == 8'h00))
    else $error("split high byte wrap did not raise the timer 1 flag");

  // Divide by four must tick evenly; a skipped tick slows every fast timer
  a_div_four: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    (tick4 && $past(resetn_in, 4))
    |-> ($past(tick4, 4) && !$past(tick4, 2)))
    else $error("divide by four spacing wrong");
endmodule
`default_nettype wire

// *** sim/dmt_pin_model.sv ***
// Pin-side model: event sources, gate pins and overflow pulse counters
`default_nettype none
module dmt_pin_model
(
  input  wire logic       sys_clk_in,
  input  wire logic       resetn_in,
  input  wire logic [2:0] fall_go_in,
  input  wire logic [1:0] gate_open_in,
  input  wire logic [2:0] pulse_in,
  output logic      [2:0] event_pins_out,
  output logic      [1:0] irq_pins_out,
  output logic      [7:0] pulse_cnt_out [3]
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] low_left [3] = '{default: 3'h0};

  // one request, one falling edge
  // Pin stays low four cycles so the two-stage synchroniser cannot miss it
  always @(posedge sys_clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (fall_go_in[i]) begin
        low_left[i] <= 3'h4;
      end else if (low_left[i] != 3'h0) begin
        low_left[i] <= low_left[i] - 3'h1;
      end
    end
  end

  // Event pins idle high between requests
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      event_pins_out[i] = (low_left[i] == 3'h0);
    end
  end

  assign irq_pins_out = gate_open_in;

  always @(posedge sys_clk_in) begin
    for (int i = 0; i < 3; i++) begin
      if (!resetn_in) begin
        pulse_cnt_out[i] <= 8'h00;
      end else if (pulse_in[i]) begin
        pulse_cnt_out[i] <= pulse_cnt_out[i] + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/tb_top.sv ***
// Self-checking bench for the dual mode timer/counter
`default_nettype none
module tb_top
  import dmt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dmt_row_t;
  typedef struct packed {
    logic t; logic [1:0] m; logic [7:0] lo; logic [7:0] hi;
    logic [7:0] elo; logic [7:0] ehi; logic [7:0] mask;
  } dmt_ovf_t;

  logic       sys_clk, resetn, wr, rd, rate0, rate1, t2_run, t2_src, t2_oe, ack0, ack1;
  logic [7:0] addr, wdata, v, v2;
  logic [2:0] fall_go;
  logic [1:0] gate_open;
  wire  [7:0] rdata;
  wire  [2:0] pulses, ev;
  wire  [1:0] irq;
  wire        oe2;
  logic [7:0] pcnt [3];
  int         errors, n_checks, cyc;

  localparam dmt_row_t ROWS [9] = '{
    '{ADDR_MODE, 8'hA5, 8'hA5}, '{ADDR_LOW_0, 8'h12, 8'h12}, '{ADDR_HIGH_0, 8'h34, 8'h34},
    '{ADDR_LOW_1, 8'h56, 8'h56}, '{ADDR_HIGH_1, 8'h78, 8'h78}, '{ADDR_LOW_2, 8'h9A, 8'h9A},
    '{ADDR_HIGH_2, 8'hBC, 8'hBC}, '{ADDR_CONTROL, 8'hAF, 8'hA0}, '{8'h90, 8'h55, 8'h00}};
  // Timer, mode, start low/high, expected low/high after stop, low mask
  localparam dmt_ovf_t OVF [4] = '{
    '{1'b0, 2'h0, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h1F}, '{1'b0, 2'h1, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF},
    '{1'b0, 2'h2, 8'hFF, 8'h40, 8'h40, 8'h40, 8'hFF}, '{1'b1, 2'h1, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFF}};

  dmt_timer u_dut (.sys_clk_in(sys_clk), .resetn_in(resetn), .sfr_addr_in(addr),
    .sfr_wdata_in(wdata), .sfr_write_in(wr), .sfr_read_in(rd), .sfr_rdata_out(rdata),
    .event_pin_0_in(ev[0]), .event_pin_1_in(ev[1]), .event_pin_2_in(ev[2]),
    .ext_irq_pin_0_in(irq[0]), .ext_irq_pin_1_in(irq[1]), .rate_select_0_in(rate0),
    .rate_select_1_in(rate1), .timer2_run_in(t2_run), .timer2_source_in(t2_src),
    .timer2_out_enable_in(t2_oe), .irq_ack_0_in(ack0), .irq_ack_1_in(ack1),
    .overflow_pulse_0_out(pulses[0]), .overflow_pulse_1_out(pulses[1]),
    .overflow_pulse_2_out(pulses[2]), .overflow_pulse_2_oe_out(oe2));

  dmt_pin_model u_pins (.sys_clk_in(sys_clk), .resetn_in(resetn), .fall_go_in(fall_go),
    .gate_open_in(gate_open), .pulse_in(pulses), .event_pins_out(ev),
    .irq_pins_out(irq), .pulse_cnt_out(pcnt));

  // Clock and hang guard; the ceiling is well above the longest scenario
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic check8(input string name, input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  // Read data lands on the same edge that takes the strobe, one cycle after the strobe is raised
  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic wait_pulse(input int t);
    int k;
    k = 0;
    while (pulses[t] !== 1'b1 && k < 100) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    check8("pulse seen", {7'h0, pulses[t]}, 8'h01);
    @(posedge sys_clk);
    #1;
    check8("pulse width", {7'h0, pulses[t]}, 8'h00);
  endtask

  task automatic ovf_case(input dmt_ovf_t c);
    sfr_write(ADDR_MODE, c.t ? {2'h0, c.m, 4'h0} : {6'h0, c.m});
    sfr_write(c.t ? ADDR_LOW_1 : ADDR_LOW_0, c.lo);
    sfr_write(c.t ? ADDR_HIGH_1 : ADDR_HIGH_0, c.hi);
    sfr_write(ADDR_CONTROL, c.t ? 8'h40 : 8'h10);
    wait_pulse(c.t);
    sfr_read(ADDR_CONTROL, v);
    check8("overflow flag", v, c.t ? 8'hC0 : 8'h30);
    sfr_write(ADDR_CONTROL, 8'h00);
    sfr_read(c.t ? ADDR_LOW_1 : ADDR_LOW_0, v);
    check8("low after wrap", v & c.mask, c.elo);
    sfr_read(c.t ? ADDR_HIGH_1 : ADDR_HIGH_0, v);
    check8("high after wrap", v, c.ehi);
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    int t0;
    {resetn, wr, rd, rate0, rate1, t2_run, t2_src, t2_oe, ack0, ack1} = '0;
    {addr, wdata, fall_go, gate_open} = '0;
    errors = 0;
    n_checks = 0;
    cyc = 0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    // Every register reads zero out of reset, then takes its written value; control keeps only bits 7:4, unmapped 90 reads zero
    foreach (ROWS[i]) begin
      sfr_read(ROWS[i].a, v);
      check8("reset value", v, RESET_BYTE);
    end
    foreach (ROWS[i]) begin
      sfr_write(ROWS[i].a, ROWS[i].d);
      sfr_read(ROWS[i].a, v);
      check8("register readback", v, ROWS[i].e);
    end
    sfr_write(ADDR_CONTROL, 8'h00);
    foreach (OVF[i]) ovf_case(OVF[i]);
    // Reload spacing is two prescaled ticks, /12 then /4
    sfr_write(ADDR_MODE, 8'h02);
    // Low byte starts one tick short of overflow so the first pulse comes quickly
    sfr_write(ADDR_HIGH_0, 8'hFE);
    sfr_write(ADDR_LOW_0, 8'hFF);
    sfr_write(ADDR_CONTROL, 8'h10);
    for (int r = 0; r < 2; r++) begin
      @(posedge sys_clk);
      rate0 <= r[0];
      wait_pulse(0);
      t0 = cyc;
      wait_pulse(0);
      check8("reload gap", 8'(cyc - t0), r ? 8'h08 : 8'h18);
    end
    // Vector clear lands on the next /4 overflow edge; the overflow must win
    repeat (6) @(posedge sys_clk);
    ack0 <= 1'b1;
    @(posedge sys_clk);
    ack0 <= 1'b0;
    sfr_read(ADDR_CONTROL, v);
    check8("flag beats clear", v, 8'h30);
    // Gate closed holds the count, open lets it run, run bit off stops it
    sfr_write(ADDR_MODE, 8'h09);
    sfr_write(ADDR_LOW_0, 8'h00);
    repeat (40) @(posedge sys_clk);
    sfr_read(ADDR_LOW_0, v);
    check8("gate closed", v, 8'h00);
    gate_open <= 2'h1;
    repeat (40) @(posedge sys_clk);
    sfr_write(ADDR_CONTROL, 8'h00);
    sfr_read(ADDR_LOW_0, v);
    check8("gate open", {7'h0, v != 8'h00}, 8'h01);
    repeat (40) @(posedge sys_clk);
    sfr_read(ADDR_LOW_0, v2);
    check8("run off", v2, v);
    // Five falling edges on the event pin give exactly five counts
    sfr_write(ADDR_MODE, 8'h05);
    sfr_write(ADDR_LOW_0, 8'h00);
    sfr_write(ADDR_CONTROL, 8'h10);
    repeat (5) begin
      @(posedge sys_clk);
      fall_go <= 3'h1;
      @(posedge sys_clk);
      fall_go <= 3'h0;
      repeat (10) @(posedge sys_clk);
    end
    sfr_read(ADDR_LOW_0, v);
    check8("event count", v, 8'h05);
    // Split timer 0 with timer 1 parked in mode 3
    sfr_write(ADDR_CONTROL, 8'h00);
    t0 = pcnt[0];
    sfr_write(ADDR_MODE, 8'h33);
    sfr_write(ADDR_LOW_0, 8'h80);
    sfr_write(ADDR_HIGH_0, 8'hFF);
    sfr_write(ADDR_LOW_1, 8'h11);
    sfr_write(ADDR_CONTROL, 8'h40);
    repeat (30) @(posedge sys_clk);
    sfr_read(ADDR_CONTROL, v);
    check8("split high flag", v, 8'hC0);
    sfr_read(ADDR_LOW_0, v);
    check8("split low idle", v, 8'h80);
    sfr_read(ADDR_LOW_1, v);
    check8("timer 1 stopped", v, 8'h11);
    check8("no low pulse", pcnt[0], 8'(t0));
    @(posedge sys_clk);
    ack1 <= 1'b1;
    @(posedge sys_clk);
    ack1 <= 1'b0;
    sfr_read(ADDR_CONTROL, v);
    check8("flag cleared", v, 8'h40);
    // Timer 2 wraps from all ones and pulses its enabled pin
    sfr_write(ADDR_LOW_2, 8'hFF);
    sfr_write(ADDR_HIGH_2, 8'hFF);
    t2_oe <= 1'b1;
    t2_run <= 1'b1;
    wait_pulse(2);
    check8("timer 2 enable", {7'h0, oe2}, 8'h01);
    // Mid-run reset clears control, mode and a running count
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    sfr_read(ADDR_CONTROL, v);
    check8("control after reset", v, RESET_BYTE);
    sfr_read(ADDR_MODE, v);
    check8("mode after reset", v, RESET_BYTE);
    sfr_read(ADDR_HIGH_0, v);
    check8("count after reset", v, RESET_BYTE);
    report_and_stop();
  end
endmodule
`default_nettype wire
